// [file_ram.sv]
// file register memory, one write port, one registered read port
// assumes write and read addresses are valid every cycle
`timescale 1ns/1ns
`default_nettype none

module file_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

// [rotate_set_sleep_instr.sv]
// execution datapath: rotates, set register, sleep, small watchdog
// assumes instr_word is stable during the decode phase
`timescale 1ns/1ns
`default_nettype none
`include "rsi_map.svh"

module rotate_set_sleep_instr #(
  parameter int BANK_W = 4,
  parameter int WDOG_W = 8,
  parameter int PS_W   = 4
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [15:0] instr_word,
  input  wire logic        wake_req,
  input  wire logic [2:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output var  logic [7:0]  bus_rdata,
  output var  logic        sleep_active
);

  localparam int AW = BANK_W + 8;

  // ----------------------------------------------------------
  // reset release
  // ----------------------------------------------------------
  logic rst_meta;
  logic rst_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_q    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_q    <= rst_meta;
    end
  end

  // ----------------------------------------------------------
  // phase sequencing and decode
  // ----------------------------------------------------------
  rsi_pkg::phase_t phase;
  rsi_pkg::phase_t next_phase;
  rsi_pkg::op_t    op;
  rsi_pkg::op_t    next_op;
  logic [AW-1:0]   fa;
  logic [AW-1:0]   next_fa;
  logic            dest_w;
  logic            next_dest_w;
  logic [7:0]      result;
  logic [7:0]      next_result;
  logic            res_carry;
  logic            next_res_carry;
  logic [7:0]      rdata;
  logic [BANK_W-1:0] bank;
  logic            carry;
  logic            ram_we;

  always_comb begin
    next_phase     = phase;
    next_op        = op;
    next_fa        = fa;
    next_dest_w    = dest_w;
    next_result    = result;
    next_res_carry = res_carry;
    unique case (phase)
      rsi_pkg::PH_DECODE: begin
        next_phase  = rsi_pkg::PH_READ;
        next_op     = rsi_pkg::OP_NONE;
        next_dest_w = ~instr_word[9];
        if (instr_word[8]) begin
          next_fa = {bank, instr_word[7:0]};
        end else if (instr_word[7]) begin
          next_fa = {`ACC_HI_BANK, instr_word[7:0]};
        end else begin
          next_fa = {`ACC_LO_BANK, instr_word[7:0]};
        end
        if (!sleep_active) begin
          if (instr_word[15:10] == `PAT_ROT_RIGHT) begin
            next_op = rsi_pkg::OP_ROT_RIGHT;
          end else if (instr_word[15:10] == `PAT_ROT_LEFT) begin
            next_op = rsi_pkg::OP_ROT_LEFT;
          end else if (instr_word[15:10] == `PAT_ROT_CARRY) begin
            next_op = rsi_pkg::OP_ROT_CARRY;
          end else if (instr_word[15:9] == `PAT_SET_ONES) begin
            next_op     = rsi_pkg::OP_SET_ONES;
            next_dest_w = 1'b0;
          end else if (instr_word == `CODE_SLEEP) begin
            next_op = rsi_pkg::OP_SLEEP;
          end
        end
      end
      rsi_pkg::PH_READ: begin
        next_phase = rsi_pkg::PH_PROCESS;
      end
      rsi_pkg::PH_PROCESS: begin
        next_phase     = rsi_pkg::PH_WRITE;
        next_res_carry = carry;
        unique case (op)
          rsi_pkg::OP_ROT_RIGHT: next_result = {rdata[0], rdata[7:1]};
          rsi_pkg::OP_ROT_LEFT:  next_result = {rdata[6:0], rdata[7]};
          rsi_pkg::OP_ROT_CARRY: begin
            next_result    = {carry, rdata[7:1]};
            next_res_carry = rdata[0];
          end
          rsi_pkg::OP_SET_ONES: next_result = `ALL_ONES;
          default:          next_result = result;
        endcase
      end
      rsi_pkg::PH_WRITE: begin
        next_phase = rsi_pkg::PH_DECODE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      phase     <= rsi_pkg::PH_DECODE;
      op        <= rsi_pkg::OP_NONE;
      fa        <= '0;
      dest_w    <= 1'b0;
      result    <= `ZERO_BYTE;
      res_carry <= 1'b0;
    end else begin
      phase     <= next_phase;
      op        <= next_op;
      fa        <= next_fa;
      dest_w    <= next_dest_w;
      result    <= next_result;
      res_carry <= next_res_carry;
    end
  end

  // ----------------------------------------------------------
  // file registers: read address held from decode, write in phase four
  // ----------------------------------------------------------
  logic is_rot;
  logic wr_phase;

  assign is_rot   = (op == rsi_pkg::OP_ROT_RIGHT) ||
                    (op == rsi_pkg::OP_ROT_LEFT) ||
                    (op == rsi_pkg::OP_ROT_CARRY);
  assign wr_phase = (phase == rsi_pkg::PH_WRITE);
  assign ram_we   = wr_phase && ((is_rot && !dest_w) ||
                    (op == rsi_pkg::OP_SET_ONES));

  file_ram #(
    .AW (AW),
    .DW (8)
  ) u_ram (
    .clk   (clk),
    .we    (ram_we),
    .waddr (fa),
    .wdata (result),
    .raddr (fa),
    .rdata (rdata)
  );

  // ----------------------------------------------------------
  // watchdog counter and postscaler
  // ----------------------------------------------------------
  logic [WDOG_W-1:0] wdog;
  logic [WDOG_W-1:0] next_wdog;
  logic [PS_W-1:0]   pscale;
  logic [PS_W-1:0]   next_pscale;
  logic              timeout;
  logic              do_sleep;

  assign do_sleep = wr_phase && (op == rsi_pkg::OP_SLEEP);
  assign timeout  = (&wdog) && (&pscale);

  always_comb begin
    next_wdog   = wdog + 1'b1;
    next_pscale = (&wdog) ? pscale + 1'b1 : pscale;
    if (do_sleep) begin
      next_wdog   = '0;
      next_pscale = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      wdog   <= '0;
      pscale <= '0;
    end else begin
      wdog   <= next_wdog;
      pscale <= next_pscale;
    end
  end

  // ----------------------------------------------------------
  // working register, status, bank, sleep; hardware beats software
  // ----------------------------------------------------------
  logic [7:0]        work;
  logic [7:0]        next_work;
  logic              next_carry;
  logic              zero;
  logic              next_zero;
  logic              neg;
  logic              next_neg;
  logic              pwr_down;
  logic              next_pwr_down;
  logic              timed_out;
  logic              next_timed_out;
  logic [BANK_W-1:0] next_bank;
  logic              next_sleep;

  always_comb begin
    next_work  = work;
    next_carry = carry;
    next_zero  = zero;
    next_neg   = neg;
    next_pwr_down  = pwr_down;
    next_timed_out = timed_out;
    next_bank  = bank;
    next_sleep = sleep_active;
    if (bus_wr) begin
      unique case (bus_addr)
        `REG_WORK: next_work = bus_wdata;
        `REG_STATUS: begin
          next_carry = bus_wdata[`ST_CARRY];
          next_zero  = bus_wdata[`ST_ZERO];
          next_neg   = bus_wdata[`ST_NEG];
          next_pwr_down  = bus_wdata[`ST_PWR_DOWN];
          next_timed_out = bus_wdata[`ST_TIMEOUT];
        end
        `REG_BANK: next_bank = bus_wdata[BANK_W-1:0];
        default: next_bank = bank;
      endcase
    end
    if (wr_phase && is_rot) begin
      next_zero = (result == `ZERO_BYTE);
      next_neg  = result[7];
      if (op == rsi_pkg::OP_ROT_CARRY) begin
        next_carry = res_carry;
      end
      if (dest_w) begin
        next_work = result;
      end
    end
    if (do_sleep) begin
      next_sleep = 1'b1;
      next_pwr_down  = 1'b0;
      next_timed_out = 1'b1;
    end else if (sleep_active && timeout) begin
      next_sleep     = 1'b0;
      next_timed_out = 1'b0;
    end else if (sleep_active && wake_req) begin
      next_sleep = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      work         <= `ZERO_BYTE;
      carry        <= 1'b0;
      zero         <= 1'b0;
      neg          <= 1'b0;
      pwr_down     <= `RST_PWR_DOWN;
      timed_out    <= `RST_TIMEOUT;
      bank         <= '0;
      sleep_active <= 1'b0;
    end else begin
      work         <= next_work;
      carry        <= next_carry;
      zero         <= next_zero;
      neg          <= next_neg;
      pwr_down     <= next_pwr_down;
      timed_out    <= next_timed_out;
      bank         <= next_bank;
      sleep_active <= next_sleep;
    end
  end

  // ----------------------------------------------------------
  // software read port
  // ----------------------------------------------------------
  logic [7:0] next_rdata;
  logic [7:0] status_byte;

  always_comb begin
    status_byte            = `ZERO_BYTE;
    status_byte[`ST_CARRY] = carry;
    status_byte[`ST_ZERO]  = zero;
    status_byte[`ST_NEG]   = neg;
    status_byte[`ST_PWR_DOWN] = pwr_down;
    status_byte[`ST_TIMEOUT]  = timed_out;
    next_rdata             = `ZERO_BYTE;
    if (bus_rd) begin
      unique case (bus_addr)
        `REG_WORK:   next_rdata = work;
        `REG_STATUS: next_rdata = status_byte;
        `REG_BANK:   next_rdata = 8'(bank);
        `REG_WDOG:   next_rdata = 8'(wdog);
        `REG_PSCALE: next_rdata = 8'(pscale);
        `REG_SLEEP:  next_rdata = {7'h00, sleep_active};
        default:     next_rdata = `ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      bus_rdata <= `ZERO_BYTE;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_q);

  AST_ROR_RESULT: assert property (
    phase == rsi_pkg::PH_PROCESS && op == rsi_pkg::OP_ROT_RIGHT |=>
      result == {$past(rdata[0]), $past(rdata[7:1])})
    else $error("rotate right result wrong");
  AST_DECODE_ROR: assert property (
    phase == rsi_pkg::PH_DECODE && !sleep_active &&
    instr_word[15:10] == `PAT_ROT_RIGHT |=> op == rsi_pkg::OP_ROT_RIGHT)
    else $error("rotate right not decoded");
  AST_ROR_CARRY: assert property (
    wr_phase && op == rsi_pkg::OP_ROT_RIGHT && !bus_wr |=>
      carry == $past(carry) && zero == ($past(result) == `ZERO_BYTE))
    else $error("rotate right flags wrong");
  AST_DEST_W: assert property (
    wr_phase && is_rot && dest_w && !bus_wr |-> !ram_we ##1
      work == $past(result))
    else $error("working destination wrong");
  AST_BANK_SEL: assert property (
    phase == rsi_pkg::PH_DECODE && instr_word[8] |=>
      fa == {$past(bank), $past(instr_word[7:0])})
    else $error("bank address wrong");
  AST_SET_ONES: assert property (
    wr_phase && op == rsi_pkg::OP_SET_ONES && !bus_wr |->
      ram_we && result == `ALL_ONES ##1 $stable(status_byte))
    else $error("set register wrong");
  AST_DECODE_SET: assert property (
    phase == rsi_pkg::PH_DECODE && !sleep_active &&
    instr_word[15:9] == `PAT_SET_ONES |=> op == rsi_pkg::OP_SET_ONES)
    else $error("set register not decoded");
  AST_SLEEP: assert property (
    do_sleep |=> sleep_active && !pwr_down && timed_out &&
      wdog == '0 && pscale == '0)
    else $error("sleep entry wrong");
  AST_WDOG_WAKE: assert property (
    sleep_active && timeout && !do_sleep |=> !sleep_active && !timed_out)
    else $error("watchdog wake wrong");
  AST_ROT_CARRY: assert property (
    phase == rsi_pkg::PH_PROCESS && op == rsi_pkg::OP_ROT_CARRY |=>
      result == {$past(carry), $past(rdata[7:1])} &&
      res_carry == $past(rdata[0]))
    else $error("rotate through carry wrong");
  AST_PHASES: assert property (
    phase == rsi_pkg::PH_DECODE |=> phase == rsi_pkg::PH_READ ##1
      phase == rsi_pkg::PH_PROCESS ##1 phase == rsi_pkg::PH_WRITE)
    else $error("phase order wrong");

  COV_ROR_W:  cover property (wr_phase && op == rsi_pkg::OP_ROT_RIGHT &&
                              dest_w);
  COV_SET:    cover property (wr_phase && op == rsi_pkg::OP_SET_ONES);
  COV_WAKE:   cover property (sleep_active && timeout);

endmodule

`default_nettype wire

// [rotate_set_sleep_instr_bench.sv]
// self-checking bench for the rotate / set / sleep execution block
// assumes file memory reachable as dut_u.u_ram.mem with 12-bit address
`timescale 1ns/1ns
`default_nettype none

module rotate_set_sleep_instr_bench;
  logic        clk;
  logic        rstn;
  logic [15:0] instr_word;
  logic        wake_req;
  logic [2:0]  bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_rdata;
  logic        sleep_active;
  int          errors;
  int          num_checks;
  int          n;
  logic [7:0]  rd;

  // ------------------------------------------------------------
  // device under test, short watchdog for quick wake-up
  // ------------------------------------------------------------
  rotate_set_sleep_instr #(
    .BANK_W (4),
    .WDOG_W (2),
    .PS_W   (1)
  ) dut_u (
    .clk          (clk),
    .rstn         (rstn),
    .instr_word   (instr_word),
    .wake_req     (wake_req),
    .bus_addr     (bus_addr),
    .bus_wdata    (bus_wdata),
    .bus_wr       (bus_wr),
    .bus_rd       (bus_rd),
    .bus_rdata    (bus_rdata),
    .sleep_active (sleep_active)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // register port and instruction stream
  // ------------------------------------------------------------
  task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
  endtask

  task automatic bus_read(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1;
    v = bus_rdata;
  endtask

  task automatic check_reg(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    bus_read(a, v);
    check(v, exp);
  endtask

  // four cycles of hold cover exactly one decode edge
  task automatic exec(input logic [15:0] i);
    @(posedge clk);
    instr_word <= i;
    repeat (4) @(posedge clk);
    instr_word <= 16'h0000;
    repeat (5) @(posedge clk);
  endtask

  task automatic wait_sleep(input logic level);
    n = 0;
    while (sleep_active !== level && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic enter_sleep;
    @(posedge clk);
    instr_word <= 16'h0003;
    repeat (4) @(posedge clk);
    instr_word <= 16'h0000;
    wait_sleep(1'b1);
  endtask

  // ------------------------------------------------------------
  // watchdog against a hang
  // ------------------------------------------------------------
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    tally_and_finish;
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    rstn       = 1'b0;
    instr_word = 16'h0000;
    wake_req   = 1'b0;
    bus_addr   = 3'h0;
    bus_wdata  = 8'h00;
    bus_wr     = 1'b0;
    bus_rd     = 1'b0;
    errors     = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    check_reg(3'h1, 8'h18);
    check_reg(3'h0, 8'h00);
    check_reg(3'h5, 8'h00);
    dut_u.u_ram.mem[12'h340] = 8'hd7;
    dut_u.u_ram.mem[12'h040] = 8'h11;
    dut_u.u_ram.mem[12'hf90] = 8'hab;
    dut_u.u_ram.mem[12'h020] = 8'h01;
    dut_u.u_ram.mem[12'h341] = 8'h00;
    bus_write(3'h2, 8'h03);
    bus_write(3'h1, 8'h19);
    check_reg(3'h2, 8'h03);
    // rotate right, file destination, banked
    exec(16'h4340);
    check(dut_u.u_ram.mem[12'h340], 8'heb);
    check(dut_u.u_ram.mem[12'h040], 8'h11);
    check_reg(3'h1, 8'h1d);
    // rotate right into working register, access bank
    exec(16'h4040);
    check_reg(3'h0, 8'h88);
    check(dut_u.u_ram.mem[12'h040], 8'h11);
    check_reg(3'h1, 8'h1d);
    // rotate left, upper half of access bank
    exec(16'h4490);
    check_reg(3'h0, 8'h57);
    check_reg(3'h1, 8'h19);
    // rotate through carry: carry in and carry out
    exec(16'h3220);
    check(dut_u.u_ram.mem[12'h020], 8'h80);
    check_reg(3'h1, 8'h1d);
    exec(16'h3220);
    check(dut_u.u_ram.mem[12'h020], 8'hc0);
    check_reg(3'h1, 8'h1c);
    // zero result
    exec(16'h4341);
    check(dut_u.u_ram.mem[12'h341], 8'h00);
    check_reg(3'h1, 8'h1a);
    // set register, both bank modes
    exec(16'h6941);
    check(dut_u.u_ram.mem[12'h341], 8'hff);
    check_reg(3'h1, 8'h1a);
    check_reg(3'h0, 8'h57);
    exec(16'h6820);
    check(dut_u.u_ram.mem[12'h020], 8'hff);
    // read-only and unmapped offsets
    bus_write(3'h5, 8'h01);
    check_reg(3'h5, 8'h00);
    check_reg(3'h7, 8'h00);
    // sleep, woken by watchdog after a full count
    enter_sleep;
    check({7'h00, sleep_active}, 8'h01);
    wait_sleep(1'b0);
    check({7'h00, (n >= 7 && n <= 9)}, 8'h01);
    check_reg(3'h1, 8'h02);
    // sleep again, woken by external request
    enter_sleep;
    check_reg(3'h1, 8'h12);
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    wait_sleep(1'b0);
    check({7'h00, sleep_active}, 8'h00);
    check_reg(3'h1, 8'h12);
    exec(16'h4040);
    check_reg(3'h0, 8'h88);
    tally_and_finish;
  end
endmodule

`default_nettype wire

// [rsi_map.svh]
// constants for the rotate / set / sleep execution block
// assumes one 8-bit data path and a 16-bit instruction word
//
// Contract
// - rotate right: bit n to n-1, bit0 to 7
// - rotate right opcode upper bits 0100 00
// - rotate right sets only negative and zero
// - d=0 writes working register, d=1 file
// - a=0 access bank, a=1 uses bank register
// - working destination leaves source file unchanged
// - set register loads ones, no flags
// - set register opcode upper bits 0110 100
// - sleep: clear power-down, set timeout, clear watchdog
// - rotate left no carry, opcode 0100 01
// - watchdog wake clears the timeout flag
`ifndef RSI_MAP_SVH
`define RSI_MAP_SVH

// ------------------------------------------------------------
// opcode patterns
// ------------------------------------------------------------
`define PAT_ROT_RIGHT 6'h10
`define PAT_ROT_LEFT  6'h11
`define PAT_ROT_CARRY 6'h0C
`define PAT_SET_ONES  7'h34
`define CODE_SLEEP    16'h0003
`define ALL_ONES      8'hFF
`define ZERO_BYTE     8'h00

// ------------------------------------------------------------
// access bank split: low half in bank 0, high half in last bank
// ------------------------------------------------------------
`define ACC_LO_BANK   4'h0
`define ACC_HI_BANK   4'hF

// ------------------------------------------------------------
// register offsets on the software port
// ------------------------------------------------------------
`define REG_WORK      3'h0
`define REG_STATUS    3'h1
`define REG_BANK      3'h2
`define REG_WDOG      3'h3
`define REG_PSCALE    3'h4
`define REG_SLEEP     3'h5

// ------------------------------------------------------------
// status bit positions and reset values
// ------------------------------------------------------------
`define ST_CARRY      0
`define ST_ZERO       1
`define ST_NEG        2
`define ST_PWR_DOWN   3
`define ST_TIMEOUT    4
`define RST_PWR_DOWN  1'h1
`define RST_TIMEOUT   1'h1

`endif

// [rsi_pkg.sv]
// types shared by the execution block
// assumes nothing beyond a SystemVerilog compiler
package rsi_pkg;

  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } phase_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ROT_RIGHT,
    OP_ROT_LEFT,
    OP_ROT_CARRY,
    OP_SET_ONES,
    OP_SLEEP
  } op_t;

endpackage
